// file: mip_addr_pkg.sv
// constants, enumerations and field widths for the mip surface address generator
// assumes a single core clock; surface state is held steady by the driver while in use
// Contract
// - buffer is array of structures, max 2048
// - buffer structures packed back to back, linear
// - 1D surfaces act as height-one 2D
// - stencil surface is one unsigned byte
// - base address is upper-left of level zero
// - uncompressed levels start on even rows
// - compressed levels stack directly, block padded
// - pitch alignment dword linear, 16 bytes tiled
// - level size halves, clamped at one
// - padded size is alignment times ceiling
// - side layout: level one right, stack down
// - under layout: level one below, two right
// - alignment width 4, eight-wide 8; height 4
// - other alignment height: stencil 4, else 2
// - address is base plus row and column terms
// - texel rows per row and bytes per texel
// - byte pitch is dword pitch times four
// - level corners sit on alignment unit multiples
// - compressed block row covers four texel rows; code does this for eight-wide only, block compressed uses one
// - slice stride times index adds to y
package mip_addr_pkg;

  localparam int ADDR_W     = 32;
  localparam int DIM_W      = 14;
  localparam int PAD_W      = DIM_W + 1;
  localparam int LOD_W      = 4;
  localparam int MAX_LEVELS = 15;
  localparam int X_W        = 16;
  localparam int Y_W        = 24;
  localparam int PITCH_W    = 12;
  localparam int PBYTE_W    = PITCH_W + 2;
  localparam int STRUCT_W   = 12;
  localparam int IDX_W      = 11;
  localparam int STRIDE_W   = 14;
  localparam int LATENCY    = 2;

  // largest structure a buffer may hold, in bytes
  localparam logic [STRUCT_W:0] STRUCT_MAX_BYTES = 13'h0800;

  // alignment unit sizes as log2
  localparam logic [1:0] ALIGN_W_STD_LOG2  = 2'h2;
  localparam logic [1:0] ALIGN_W_WIDE_LOG2 = 2'h3;
  localparam logic [1:0] ALIGN_H_TALL_LOG2 = 2'h2;
  localparam logic [1:0] ALIGN_H_STD_LOG2  = 2'h1;

  // texel rows per memory row as log2
  localparam logic [1:0] ROWS_WIDE_LOG2 = 2'h2;
  localparam logic [1:0] ROWS_STD_LOG2  = 2'h0;

  // dword pitch to byte pitch, and tiled pitch must be a multiple of four dwords
  localparam logic [1:0] DW_BYTES_LOG2    = 2'h2;
  localparam logic [1:0] TILED_PITCH_MASK = 2'h3;

  // block compressed texel footprint
  localparam logic [1:0] BLOCK_ROW_MASK = 2'h3;

  typedef enum logic [1:0] {
    SURF_BUFFER  = 2'h0,
    SURF_1D      = 2'h1,
    SURF_2D      = 2'h2,
    SURF_STENCIL = 2'h3
  } surf_kind_t;

  typedef enum logic [2:0] {
    FMT_PLAIN                   = 3'h0,
    FMT_FOUR_BIT                = 3'h1,
    FMT_YUV422                  = 3'h2,
    FMT_BLOCK_COMPRESSED        = 3'h3,
    FMT_EIGHT_WIDE_COMPRESSED   = 3'h4
  } fmt_class_t;

  // bytes per texel: code n means 2^n half bytes
  typedef enum logic [2:0] {
    BPT_HALF = 3'h0,
    BPT_1    = 3'h1,
    BPT_2    = 3'h2,
    BPT_4    = 3'h3,
    BPT_8    = 3'h4,
    BPT_16   = 3'h5
  } bpt_t;

  typedef enum logic [1:0] {
    MIP_LAYOUT_SIDE  = 2'h0,
    MIP_LAYOUT_UNDER = 2'h1,
    MIP_LAYOUT_OLD   = 2'h3
  } mip_layout_t;

endpackage

// file: mip_level_dims.sv
// size of one mip level, clamped, and padded to the alignment unit
// assumes alignment sizes are powers of two given as log2
`timescale 1ns/10ps
`default_nettype none
module mip_level_dims
  import mip_addr_pkg::*;
#(
  parameter int LEVEL = 0
) (
  // base level size
  input  wire logic [DIM_W-1:0] base_width,
  input  wire logic [DIM_W-1:0] base_height,
  // alignment unit
  input  wire logic [1:0]       i_log2,
  input  wire logic [1:0]       j_log2,
  // padded size of this level
  output logic      [PAD_W-1:0] pad_width,
  output logic      [PAD_W-1:0] pad_height
);

  logic [DIM_W-1:0] lvl_w;
  logic [DIM_W-1:0] lvl_h;
  logic [PAD_W:0]   sum_w;
  logic [PAD_W:0]   sum_h;

  always_comb begin
    lvl_w = base_width >> LEVEL;
    lvl_h = base_height >> LEVEL;
    if (lvl_w == '0) begin
      lvl_w = DIM_W'(1);
    end
    if (lvl_h == '0) begin
      lvl_h = DIM_W'(1);
    end
    sum_w = (PAD_W + 1)'(lvl_w) + ((PAD_W + 1)'(1) << i_log2) - (PAD_W + 1)'(1);
    sum_h = (PAD_W + 1)'(lvl_h) + ((PAD_W + 1)'(1) << j_log2) - (PAD_W + 1)'(1);
    pad_width  = PAD_W'((sum_w >> i_log2) << i_log2);
    pad_height = PAD_W'((sum_h >> j_log2) << j_log2);
  end

endmodule
`default_nettype wire

// file: texel_to_byte.sv
// cartesian texel position to linear byte address
// assumes y is a multiple of the texel rows per memory row
`timescale 1ns/10ps
`default_nettype none
module texel_to_byte
  import mip_addr_pkg::*;
(
  // surface
  input  wire logic [ADDR_W-1:0]  base,
  input  wire logic [PBYTE_W-1:0] pitch_bytes,
  input  wire bpt_t               bpt,
  input  wire logic [1:0]         rows_log2,
  // position
  input  wire logic [X_W-1:0]     x,
  input  wire logic [Y_W-1:0]     y,
  // result
  output logic      [ADDR_W-1:0]  lin_addr
);

  logic [Y_W+PBYTE_W-1:0] row_term;
  logic [X_W+7:0]         col_term;

  always_comb begin
    row_term = ((Y_W + PBYTE_W)'(y) * (Y_W + PBYTE_W)'(pitch_bytes)) >> rows_log2;
    // half byte units keep the half-byte formats exact
    col_term = (((X_W + 8)'(x) << rows_log2) << bpt) >> 1;
    lin_addr = base + ADDR_W'(row_term) + ADDR_W'(col_term);
  end

endmodule
`default_nettype wire

// file: mip_surface_address_gen.sv
// surface address generator: level sizes, level corners, byte addresses
// assumes surface state is stable while requests that use it are in flight
`timescale 1ns/10ps
`default_nettype none
module mip_surface_address_gen
  import mip_addr_pkg::*;
#(
  parameter int LEVELS = MAX_LEVELS
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // surface state
  input  wire surf_kind_t          surf_kind,
  input  wire fmt_class_t          fmt_class,
  input  wire bpt_t                bpt_code,
  input  wire logic                tiled,
  input  wire mip_layout_t         mip_layout,
  input  wire logic [DIM_W-1:0]    surf_width,
  input  wire logic [DIM_W-1:0]    surf_height,
  input  wire logic [PITCH_W-1:0]  pitch_dw,
  input  wire logic [STRUCT_W:0]   struct_bytes,
  input  wire logic [ADDR_W-1:0]   base_addr,
  input  wire logic [STRIDE_W-1:0] slice_row_stride,
  // request
  input  wire logic                req_valid,
  input  wire logic [LOD_W-1:0]    req_lod,
  input  wire logic [X_W-1:0]      req_x,
  input  wire logic [X_W-1:0]      req_y,
  input  wire logic [IDX_W-1:0]    req_array_idx,
  input  wire logic [STRUCT_W-1:0] req_elem_off,
  // answer
  output logic                     addr_valid,
  output logic      [ADDR_W-1:0]   addr,
  output logic                     addr_err
);

  typedef struct packed {
    logic               s1_valid;
    logic               s1_buffer;
    logic               s1_err;
    logic [ADDR_W-1:0]  s1_base;
    logic [X_W-1:0]     s1_x;
    logic [Y_W-1:0]     s1_y;
    logic [PBYTE_W-1:0] s1_pitch_bytes;
    bpt_t               s1_bpt;
    logic [1:0]         s1_rows_log2;
    logic               s2_valid;
    logic               s2_err;
    logic [ADDR_W-1:0]  s2_addr;
  } pipe_t;

  pipe_t state_reg;
  pipe_t state_next;

  logic rst_meta_reg;
  logic rst_core_reg;

  // async assert, sync release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_core_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_core_reg <= rst_meta_reg;
    end
  end

  logic             is_eight;
  logic             is_comp;
  logic             is_stencil;
  logic [1:0]       i_log2;
  logic [1:0]       j_log2;
  logic [1:0]       rows_log2;
  logic [DIM_W-1:0] eff_height;
  bpt_t             eff_bpt;
  logic [LOD_W-1:0] eff_lod;

  always_comb begin
    is_eight   = (fmt_class == FMT_EIGHT_WIDE_COMPRESSED);
    is_comp    = is_eight || (fmt_class == FMT_BLOCK_COMPRESSED);
    is_stencil = (surf_kind == SURF_STENCIL);
    i_log2 = is_eight ? ALIGN_W_WIDE_LOG2 : ALIGN_W_STD_LOG2;
    j_log2 = (is_comp || is_stencil) ? ALIGN_H_TALL_LOG2 : ALIGN_H_STD_LOG2;
    // eight-wide block row is four texel rows; block compressed uses one
    rows_log2 = is_eight ? ROWS_WIDE_LOG2 : ROWS_STD_LOG2;
    eff_height = (surf_kind == SURF_1D) ? DIM_W'(1) : surf_height;
    case (fmt_class)
      FMT_FOUR_BIT, FMT_EIGHT_WIDE_COMPRESSED: eff_bpt = BPT_HALF;
      FMT_YUV422:                              eff_bpt = BPT_2;
      default:                                 eff_bpt = bpt_code;
    endcase
    if (is_stencil) begin
      eff_bpt = BPT_1;
    end
    if (is_stencil) begin
      eff_lod = '0;
    end else if (req_lod > LOD_W'(LEVELS - 1)) begin
      eff_lod = LOD_W'(LEVELS - 1);
    end else begin
      eff_lod = req_lod;
    end
  end

  logic [PAD_W-1:0] w_pad [LEVELS];
  logic [PAD_W-1:0] h_pad [LEVELS];
  logic [Y_W-1:0]   cum_h [LEVELS+1];

  assign cum_h[0] = '0;

  // even rows come from a height unit of two
  // compressed levels abut, padded to blocks
  for (genvar g = 0; g < LEVELS; g++) begin : g_level
    mip_level_dims #(
      .LEVEL (g)
    ) u_dims (
      .base_width  (surf_width),
      .base_height (eff_height),
      .i_log2      (i_log2),
      .j_log2      (j_log2),
      .pad_width   (w_pad[g]),
      .pad_height  (h_pad[g])
    );
    assign cum_h[g+1] = cum_h[g] + Y_W'(h_pad[g]);
  end

  logic [X_W-1:0]    corner_x;
  logic [Y_W-1:0]    corner_y;
  logic [X_W-1:0]    mask_x;
  logic              req_err;
  logic [ADDR_W-1:0] buf_addr;

  always_comb begin
    corner_x = '0;
    corner_y = '0;
    case (mip_layout)
      MIP_LAYOUT_SIDE: begin
        if (eff_lod != '0) begin
          corner_x = X_W'(w_pad[0]);
          corner_y = cum_h[eff_lod] - Y_W'(h_pad[0]);
        end
      end
      MIP_LAYOUT_UNDER: begin
        if (eff_lod == LOD_W'(1)) begin
          corner_y = Y_W'(h_pad[0]);
        end else if (eff_lod != '0) begin
          corner_x = X_W'(w_pad[1]);
          corner_y = cum_h[eff_lod] - Y_W'(h_pad[1]);
        end
      end
      default: begin
        corner_y = cum_h[eff_lod];
      end
    endcase
    // offsets inside a compressed level stay on blocks
    mask_x  = (X_W'(1) << i_log2) - X_W'(1);
    req_err = is_comp && (((req_x & mask_x) != '0) || ((req_y[1:0] & BLOCK_ROW_MASK) != '0));
    // tiled pitch holds whole 16-byte units
    if (tiled && ((pitch_dw[1:0] & TILED_PITCH_MASK) != '0)) begin
      req_err = 1'b1;
    end
    if (surf_kind == SURF_BUFFER) begin
      req_err = tiled || (struct_bytes == '0) || (struct_bytes > STRUCT_MAX_BYTES);
    end
    buf_addr = base_addr + ADDR_W'((X_W + STRUCT_W + 1)'(req_x) * (X_W + STRUCT_W + 1)'(struct_bytes))
             + ADDR_W'(req_elem_off);
  end

  logic [ADDR_W-1:0] lin_addr;

  texel_to_byte u_conv (
    .base        (state_reg.s1_base),
    .pitch_bytes (state_reg.s1_pitch_bytes),
    .bpt         (state_reg.s1_bpt),
    .rows_log2   (state_reg.s1_rows_log2),
    .x           (state_reg.s1_x),
    .y           (state_reg.s1_y),
    .lin_addr    (lin_addr)
  );

  always_comb begin
    state_next = state_reg;
    state_next.s1_valid  = req_valid;
    state_next.s1_buffer = (surf_kind == SURF_BUFFER);
    state_next.s1_err    = req_err;
    state_next.s1_base   = (surf_kind == SURF_BUFFER) ? buf_addr : base_addr;
    state_next.s1_x      = corner_x + req_x;
    state_next.s1_y      = corner_y + Y_W'(req_y)
                         + Y_W'((IDX_W + STRIDE_W)'(req_array_idx) * (IDX_W + STRIDE_W)'(slice_row_stride));
    state_next.s1_pitch_bytes = PBYTE_W'(pitch_dw) << DW_BYTES_LOG2;
    state_next.s1_bpt         = eff_bpt;
    state_next.s1_rows_log2   = rows_log2;
    state_next.s2_valid = state_reg.s1_valid;
    state_next.s2_err   = state_reg.s1_valid && state_reg.s1_err;
    if (state_reg.s1_valid) begin
      state_next.s2_addr = state_reg.s1_buffer ? state_reg.s1_base : lin_addr;
    end
  end

  always_ff @(posedge clk or negedge rst_core_reg) begin
    if (!rst_core_reg) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign addr_valid = state_reg.s2_valid;
  assign addr       = state_reg.s2_addr;
  assign addr_err   = state_reg.s2_err;

  property p_latency;
    @(posedge clk) disable iff (!rst_core_reg)
    req_valid |-> ##2 addr_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("answer not two cycles after request");

  property p_no_spurious;
    @(posedge clk) disable iff (!rst_core_reg)
    !req_valid |-> ##2 !addr_valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");

  property p_base_corner;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && surf_kind == SURF_2D && req_lod == '0 && req_x == '0 && req_y == '0
      && req_array_idx == '0) |-> ##2 (addr == $past(base_addr, 2));
  endproperty
  a_base_corner: assert property (p_base_corner) else $error("level zero origin not at base");

  property p_pitch_row;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && surf_kind == SURF_2D && !is_eight && req_lod == '0 && req_x == '0
      && req_y == X_W'(1) && req_array_idx == '0)
      |-> ##2 (addr == $past(base_addr, 2) + ADDR_W'({$past(pitch_dw, 2), 2'h0}));
  endproperty
  a_pitch_row: assert property (p_pitch_row) else $error("row step is not four times pitch");

  property p_buffer_addr;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && surf_kind == SURF_BUFFER) |-> ##2 (addr == $past(buf_addr, 2));
  endproperty
  a_buffer_addr: assert property (p_buffer_addr) else $error("buffer element address wrong");

  property p_buffer_tiled;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && surf_kind == SURF_BUFFER && tiled) |-> ##2 addr_err;
  endproperty
  a_buffer_tiled: assert property (p_buffer_tiled) else $error("tiled buffer not flagged");

  property p_even_rows;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && !is_comp && req_y == '0 && req_array_idx == '0) |=> !state_reg.s1_y[0];
  endproperty
  a_even_rows: assert property (p_even_rows) else $error("uncompressed level on odd row");

  property p_block_rows;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && is_comp && req_y == '0 && req_array_idx == '0) |=> (state_reg.s1_y[1:0] == '0);
  endproperty
  a_block_rows: assert property (p_block_rows) else $error("compressed level off block row");

  property p_side_one;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && !is_stencil && mip_layout == MIP_LAYOUT_SIDE && req_lod == LOD_W'(1)
      && req_x == '0 && req_y == '0 && req_array_idx == '0)
      |=> (state_reg.s1_x == X_W'($past(w_pad[0])) && state_reg.s1_y == '0);
  endproperty
  a_side_one: assert property (p_side_one) else $error("side level one misplaced");

  property p_under_two;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && !is_stencil && mip_layout == MIP_LAYOUT_UNDER && req_lod == LOD_W'(2)
      && req_x == '0 && req_y == '0 && req_array_idx == '0)
      |=> (state_reg.s1_x == X_W'($past(w_pad[1])) && state_reg.s1_y == Y_W'($past(h_pad[0])));
  endproperty
  a_under_two: assert property (p_under_two) else $error("under level two misplaced");

  property p_one_d;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && surf_kind == SURF_1D && !is_comp) |-> (h_pad[0] == PAD_W'(2));
  endproperty
  a_one_d: assert property (p_one_d) else $error("1D level height not one padded to two");

  property p_align_w;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && is_eight) |-> (w_pad[LEVELS-1] == PAD_W'(8));
  endproperty
  a_align_w: assert property (p_align_w) else $error("eight-wide last level not one unit");

  property p_stencil;
    @(posedge clk) disable iff (!rst_core_reg)
    (req_valid && is_stencil) |=> (state_reg.s1_bpt == BPT_1);
  endproperty
  a_stencil: assert property (p_stencil) else $error("stencil not one byte per texel");

endmodule
`default_nettype wire

// file: req_source.sv
// requester model standing in for the sampler and render pipeline
// assumes one core clock; requests start only once the core is out of reset
`timescale 1ns/10ps
`default_nettype none
module req_source
  import mip_addr_pkg::*;
(
  // clock
  input  wire logic                clk,
  // request
  output logic                     req_valid,
  output logic      [LOD_W-1:0]    req_lod,
  output logic      [X_W-1:0]      req_x,
  output logic      [X_W-1:0]      req_y,
  output logic      [IDX_W-1:0]    req_array_idx,
  output logic      [STRUCT_W-1:0] req_elem_off,
  // answer
  input  wire logic                addr_valid,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic                addr_err
);
  int unsigned       cyc;
  int unsigned       sent[$];
  logic [ADDR_W-1:0] got_addr[$];
  logic              got_err[$];
  int unsigned       got_lat[$];

  initial begin
    cyc = 0;
    req_valid = 1'b0;
    req_lod = '0;
    req_x = '0;
    req_y = '0;
    req_array_idx = '0;
    req_elem_off = '0;
  end

  task automatic issue(input logic [LOD_W-1:0] lod, input logic [X_W-1:0] x,
                       input logic [X_W-1:0] y, input logic [IDX_W-1:0] idx,
                       input logic [STRUCT_W-1:0] off);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_lod = lod;
    req_x = x;
    req_y = y;
    req_array_idx = idx;
    req_elem_off = off;
  endtask

  // fields scrambled on release so a stale value cannot pass for a fresh one
  task automatic idle();
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_lod = ~req_lod;
    req_x = ~req_x;
    req_y = ~req_y;
    req_array_idx = ~req_array_idx;
    req_elem_off = ~req_elem_off;
  endtask

  // an answer with nothing outstanding is logged with latency 0
  always @(posedge clk) begin
    if (req_valid === 1'b1) begin
      sent.push_back(cyc);
    end
    if (addr_valid === 1'b1) begin
      got_addr.push_back(addr);
      got_err.push_back(addr_err);
      got_lat.push_back(sent.size() > 0 ? cyc - sent.pop_front() : 0);
    end
    cyc = cyc + 1;
  end
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the mip surface address generator
// assumes the requester model req_source and a 20 MHz core clock
`timescale 1ns/10ps
`default_nettype none
module tb
  import mip_addr_pkg::*;
;
  localparam logic [ADDR_W-1:0] B = 32'h00010000;
  logic                clk;
  logic                rst_n;
  surf_kind_t          kind;
  fmt_class_t          fmt;
  bpt_t                bpt;
  logic                tiled;
  mip_layout_t         lay;
  logic [DIM_W-1:0]    wid;
  logic [DIM_W-1:0]    hgt;
  logic [PITCH_W-1:0]  pitch;
  logic [STRUCT_W:0]   sbytes;
  logic [STRIDE_W-1:0] stride;
  logic                req_valid;
  logic [LOD_W-1:0]    req_lod;
  logic [X_W-1:0]      req_x;
  logic [X_W-1:0]      req_y;
  logic [IDX_W-1:0]    req_array_idx;
  logic [STRUCT_W-1:0] req_elem_off;
  logic                addr_valid;
  logic [ADDR_W-1:0]   addr;
  logic                addr_err;
  int                  mismatches;
  int                  checked;
  logic [ADDR_W-1:0]   exp_a[$];
  logic                exp_e[$];

  req_source u_src (.clk(clk), .req_valid(req_valid), .req_lod(req_lod), .req_x(req_x),
    .req_y(req_y), .req_array_idx(req_array_idx), .req_elem_off(req_elem_off),
    .addr_valid(addr_valid), .addr(addr), .addr_err(addr_err));

  mip_surface_address_gen u_dut (.clk(clk), .rst_n(rst_n), .surf_kind(kind),
    .fmt_class(fmt), .bpt_code(bpt), .tiled(tiled), .mip_layout(lay), .surf_width(wid),
    .surf_height(hgt), .pitch_dw(pitch), .struct_bytes(sbytes), .base_addr(B),
    .slice_row_stride(stride), .req_valid(req_valid), .req_lod(req_lod), .req_x(req_x),
    .req_y(req_y), .req_array_idx(req_array_idx), .req_elem_off(req_elem_off),
    .addr_valid(addr_valid), .addr(addr), .addr_err(addr_err));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic setsurf(input surf_kind_t k, input fmt_class_t f, input bpt_t b,
                         input logic t, input mip_layout_t l, input int w, input int h,
                         input int p);
    @(posedge clk);
    #1;
    kind = k;
    fmt = f;
    bpt = b;
    tiled = t;
    lay = l;
    wid = w[DIM_W-1:0];
    hgt = h[DIM_W-1:0];
    pitch = p[PITCH_W-1:0];
    sbytes = 13'h0800;
    stride = '0;
  endtask

  task automatic rq(input int lod, input int x, input int y, input int idx, input int off,
                    input logic [ADDR_W-1:0] a, input logic e);
    u_src.issue(lod[LOD_W-1:0], x[X_W-1:0], y[X_W-1:0], idx[IDX_W-1:0], off[STRUCT_W-1:0]);
    exp_a.push_back(a);
    exp_e.push_back(e);
  endtask

  task automatic fin(input string nm);
    int n;
    u_src.idle();
    n = 0;
    while (u_src.got_addr.size() < exp_a.size() && n < 10) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    #1;
    chk("answer count", exp_a.size(), u_src.got_addr.size());
    while (exp_a.size() > 0 && u_src.got_addr.size() > 0) begin
      chk("addr", exp_a.pop_front(), u_src.got_addr.pop_front());
      chk("err", exp_e.pop_front(), u_src.got_err.pop_front());
      chk("latency", LATENCY, u_src.got_lat.pop_front());
    end
    exp_a.delete();
    exp_e.delete();
    u_src.got_addr.delete();
    u_src.got_err.delete();
    u_src.got_lat.delete();
    if (nm != "") $display("test %s done", nm);
  endtask

  task automatic t_buffer();
    setsurf(SURF_BUFFER, FMT_PLAIN, BPT_4, 1'b0, MIP_LAYOUT_SIDE, 16, 1, 16);
    rq(0, 3, 0, 0, 5, B + 32'h1805, 1'b0);
    rq(0, 1, 0, 0, 7, B + 32'h0807, 1'b0);
    rq(0, 0, 0, 0, 0, B, 1'b0);
    fin("");
    sbytes = 13'h0801;
    rq(0, 3, 0, 0, 5, B + 32'h1808, 1'b1);
    fin("");
    sbytes = 13'h0001;
    rq(0, 7, 0, 0, 0, B + 32'h0007, 1'b0);
    fin("");
    tiled = 1'b1;
    rq(0, 3, 0, 0, 5, B + 32'h0008, 1'b1);
    fin("buffer");
  endtask

  task automatic t_layout();
    setsurf(SURF_2D, FMT_PLAIN, BPT_4, 1'b0, MIP_LAYOUT_SIDE, 16, 16, 64);
    rq(0, 0, 0, 0, 0, B, 1'b0);
    rq(1, 0, 0, 0, 0, B + 32'h0040, 1'b0);
    rq(2, 0, 0, 0, 0, B + 32'h0840, 1'b0);
    rq(3, 0, 0, 0, 0, B + 32'h0C40, 1'b0);
    rq(0, 2, 1, 0, 0, B + 32'h0108, 1'b0);
    fin("side");
    setsurf(SURF_2D, FMT_PLAIN, BPT_4, 1'b0, MIP_LAYOUT_UNDER, 16, 16, 64);
    stride = 14'h0014;
    rq(1, 0, 0, 0, 0, B + 32'h1000, 1'b0);
    rq(2, 0, 0, 0, 0, B + 32'h1020, 1'b0);
    rq(3, 0, 0, 0, 0, B + 32'h1420, 1'b0);
    rq(0, 0, 0, 2, 0, B + 32'h2800, 1'b0);
    fin("under");
    setsurf(SURF_2D, FMT_PLAIN, BPT_4, 1'b0, MIP_LAYOUT_OLD, 16, 16, 64);
    rq(1, 0, 0, 0, 0, B + 32'h1000, 1'b0);
    rq(3, 0, 0, 0, 0, B + 32'h1C00, 1'b0);
    fin("old");
    // programmed height ignored: a 1D level is one texel high
    setsurf(SURF_1D, FMT_PLAIN, BPT_4, 1'b0, MIP_LAYOUT_UNDER, 8, 4, 8);
    rq(1, 0, 0, 0, 0, B + 32'h0040, 1'b0);
    rq(2, 0, 0, 0, 0, B + 32'h0050, 1'b0);
    rq(3, 0, 0, 0, 0, B + 32'h0090, 1'b0);
    rq(4, 0, 0, 0, 0, B + 32'h00D0, 1'b0);
    fin("one row");
  endtask

  task automatic t_compress();
    setsurf(SURF_2D, FMT_EIGHT_WIDE_COMPRESSED, BPT_4, 1'b0, MIP_LAYOUT_SIDE, 32, 32, 32);
    rq(1, 0, 0, 0, 0, B + 32'h0040, 1'b0);
    rq(2, 0, 0, 0, 0, B + 32'h0240, 1'b0);
    rq(3, 0, 0, 0, 0, B + 32'h0340, 1'b0);
    rq(0, 8, 4, 0, 0, B + 32'h0090, 1'b0);
    fin("");
    setsurf(SURF_2D, FMT_BLOCK_COMPRESSED, BPT_HALF, 1'b0, MIP_LAYOUT_UNDER, 8, 6, 4);
    rq(1, 0, 0, 0, 0, B + 32'h0080, 1'b0);
    rq(2, 0, 0, 0, 0, B + 32'h0082, 1'b0);
    rq(0, 2, 0, 0, 0, B + 32'h0001, 1'b1);
    fin("compressed");
  endtask

  task automatic t_bpt();
    fmt_class_t fs[6] = '{FMT_PLAIN, FMT_FOUR_BIT, FMT_YUV422, FMT_PLAIN, FMT_PLAIN, FMT_PLAIN};
    bpt_t       bs[6] = '{BPT_16, BPT_4, BPT_1, BPT_HALF, BPT_8, BPT_4};
    logic [7:0] es[6] = '{8'h40, 8'h02, 8'h08, 8'h02, 8'h20, 8'h04};
    for (int k = 0; k < 6; k++) begin
      setsurf(k == 5 ? SURF_STENCIL : SURF_2D, fs[k], bs[k], 1'b0, MIP_LAYOUT_SIDE, 16, 16, 64);
      rq(k == 5 ? 3 : 0, 4, 0, 0, 0, B + es[k], 1'b0);
      fin("");
    end
    setsurf(SURF_2D, FMT_PLAIN, BPT_4, 1'b1, MIP_LAYOUT_SIDE, 16, 16, 65);
    rq(0, 0, 1, 0, 0, B + 32'h0104, 1'b1);
    fin("");
    setsurf(SURF_2D, FMT_PLAIN, BPT_4, 1'b1, MIP_LAYOUT_SIDE, 16, 16, 64);
    rq(0, 0, 1, 0, 0, B + 32'h0100, 1'b0);
    fin("texel size");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    mismatches = 0;
    checked = 0;
    rst_n = 1'b0;
    kind = SURF_2D;
    fmt = FMT_PLAIN;
    bpt = BPT_4;
    tiled = 1'b0;
    lay = MIP_LAYOUT_SIDE;
    wid = '0;
    hgt = '0;
    pitch = '0;
    sbytes = 13'h0800;
    stride = '0;
    repeat (10) @(posedge clk);
    #1;
    chk("reset valid", 0, addr_valid);
    chk("reset addr", 0, addr);
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    t_buffer();
    t_layout();
    t_compress();
    t_bpt();
    conclude();
  end

  // whole run needs well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
